// >>> core/mtd_pkg.sv
// mtd_pkg: register map, field positions and carrier types of the magnetic threshold block
package mtd_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_OFF_X_HI = 8'h3f;
	localparam logic [7:0] ADDR_OFF_X_LO = 8'h40;
	localparam logic [7:0] ADDR_OFF_Y_HI = 8'h41;
	localparam logic [7:0] ADDR_OFF_Y_LO = 8'h42;
	localparam logic [7:0] ADDR_OFF_Z_HI = 8'h43;
	localparam logic [7:0] ADDR_OFF_Z_LO = 8'h44;
	localparam logic [7:0] ADDR_CFG = 8'h52;
	localparam logic [7:0] ADDR_SRC = 8'h53;
	localparam logic [7:0] ADDR_THS_X_HI = 8'h54;
	localparam logic [7:0] ADDR_THS_X_LO = 8'h55;
	localparam logic [7:0] ADDR_THS_Y_HI = 8'h56;
	localparam logic [7:0] ADDR_THS_Y_LO = 8'h57;
	localparam logic [7:0] ADDR_THS_Z_HI = 8'h58;
	localparam logic [7:0] ADDR_THS_Z_LO = 8'h59;
	localparam logic [7:0] ADDR_COUNT = 8'h5a;

	// threshold_detect_config bit positions
	localparam int CFG_LATCH_BIT = 7;
	localparam int CFG_OR_SEL_BIT = 6;
	localparam int CFG_AXIS_EN_LSB = 3; // x at 3, y at 4, z at 5
	localparam int CFG_WAKE_BIT = 2;
	localparam int CFG_INT_EN_BIT = 1;
	localparam int CFG_ROUTE_BIT = 0;

	// threshold_event_source bit positions
	localparam int SRC_ACTIVE_BIT = 7;
	localparam int SRC_AXIS_LSB = 0; // per axis: polarity at 2a, event at 2a+1 (at/above in or mode, at/below in and mode)

	// counter-mode bit lives in the x threshold high byte
	localparam int DBCNT_MODE_BIT = 7;

	// values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_OFFSET = 16'h0000;
	localparam logic [14:0] RST_THRESHOLD = 15'h0000;

	localparam int NUM_AXES = 3;

	// one completed magnetic sample, signed per axis
	typedef struct packed {
		logic valid;
		logic [2:0][15:0] axis;
	} mtd_sample_s;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mtd_reg_req_s;

	// whole state of the block
	typedef struct packed {
		logic [2:0][15:0] offset;
		logic [2:0][14:0] threshold;
		logic dbcnt_clear_mode;
		logic [7:0] cfg;
		logic [7:0] count;
		logic [7:0] dbcnt;
		logic flag;
		logic [5:0] src_axis;
		logic [2:0][15:0] corr;
		logic corr_valid;
		logic [7:0] rd_data;
		logic irq_one;
		logic irq_two;
		logic wake;
	} mtd_state_s;

	localparam mtd_state_s MTD_STATE_RST = '0;

endpackage

// >>> core/mtd_threshold_detect.sv
// mtd_threshold_detect: offset correction, threshold event detection, debounce and routing
// Summary of operation
// - offsets apply only when raw select low
// - offsets are 16-bit two's complement, two bytes
// - thresholds are unsigned 15-bit per axis
// - and mode: all enabled axes at/below
// - or mode: any enabled axis at/above
// - condition must last debounce count samples
// - compare against corrected data unless raw
// - latch off: flag follows live detection
// - latch on: only source read clears flag
// - disabled axis takes no part
// - wake enable includes flag in auto-wake
// - interrupt driven only when enabled
// - route bit: zero pin two, one pin one
// - counter saturates at programmed count
// - failure clears or decrements counter by mode
// - source: active flag, per-axis event, polarity
`timescale 1ns/100ps
`default_nettype none

module mtd_threshold_detect
	import mtd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire mtd_reg_req_s reg_req,
	input wire mtd_sample_s sample,
	input wire logic raw_output_sel,
	input wire logic irq_one_other,
	input wire logic irq_two_other,
	output logic [7:0] rd_data,
	output logic [2:0][15:0] corr_data,
	output logic corr_valid,
	output logic irq_pin_one,
	output logic irq_pin_two,
	output logic wake_event
);

	mtd_state_s s_r;
	mtd_state_s s_nxt;

	logic [2:0][15:0] val;
	logic [2:0][15:0] mag;
	logic [2:0] axis_en;
	logic [2:0] at_below;
	logic [2:0] at_above;
	logic [2:0] hit;
	logic [5:0] src_bits;
	logic cond;
	logic detect;
	logic [7:0] cnt_nxt;

	// saturating signed add, so a large offset cannot wrap a reading round
	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] sum;
		sum = {a[15], a} + {b[15], b};
		if (sum[16] != sum[15]) begin
			sat_add = sum[16] ? 16'h8000 : 16'h7fff;
		end else begin
			sat_add = sum[15:0];
		end
	endfunction

	// magnitude of a signed word; full negative scale yields 16'h8000 unsigned
	function automatic logic [15:0] magnitude(input logic [15:0] v);
		magnitude = v[15] ? 16'((~v) + 16'h0001) : v;
	endfunction

	// source byte as read back, disabled axes forced to zero
	function automatic logic [7:0] src_view(input logic flag, input logic [5:0] ax,
			input logic [2:0] en);
		logic [5:0] m;
		m = {{2{en[2]}}, {2{en[1]}}, {2{en[0]}}};
		src_view = {flag, 1'b0, ax & m};
	endfunction

	// per-axis correction and comparison
	always_comb begin
		for (int i = 0; i < NUM_AXES; i++) begin
			// offset only when raw output is deselected
			val[i] = raw_output_sel ? sample.axis[i]
				: sat_add(sample.axis[i], s_r.offset[i]);
			mag[i] = magnitude(val[i]);
			axis_en[i] = s_r.cfg[CFG_AXIS_EN_LSB + i];
			at_below[i] = axis_en[i] && (mag[i] <= {1'b0, s_r.threshold[i]});
			at_above[i] = axis_en[i] && (mag[i] >= {1'b0, s_r.threshold[i]});
			hit[i] = s_r.cfg[CFG_OR_SEL_BIT] ? at_above[i] : at_below[i];
			src_bits[2 * i] = hit[i] && val[i][15]; // negative polarity
			src_bits[2 * i + 1] = hit[i];
		end
	end

	// event condition and debounce counter
	always_comb begin
		if (s_r.cfg[CFG_OR_SEL_BIT]) begin
			cond = |at_above;
		end else begin
			// nothing enabled means nothing to detect
			cond = (|axis_en) && (&(at_below | ~axis_en));
		end
		if (cond) begin
			// saturate at the count, also if the host lowered it meanwhile
			cnt_nxt = (s_r.dbcnt < s_r.count) ? 8'(s_r.dbcnt + 8'h01) : s_r.count;
		end else if (s_r.dbcnt_clear_mode) begin
			cnt_nxt = 8'h00;
		end else begin
			cnt_nxt = (s_r.dbcnt != 8'h00) ? 8'(s_r.dbcnt - 8'h01) : 8'h00;
		end
		detect = cond && (cnt_nxt >= s_r.count);
	end

	// next state: register writes and reads, then sample evaluation
	always_comb begin
		s_nxt = s_r;
		s_nxt.corr_valid = 1'b0;

		// register writes; offsets held as two bytes of one signed word
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				ADDR_OFF_X_HI: s_nxt.offset[0][15:8] = reg_req.wdata;
				ADDR_OFF_X_LO: s_nxt.offset[0][7:0] = reg_req.wdata;
				ADDR_OFF_Y_HI: s_nxt.offset[1][15:8] = reg_req.wdata;
				ADDR_OFF_Y_LO: s_nxt.offset[1][7:0] = reg_req.wdata;
				ADDR_OFF_Z_HI: s_nxt.offset[2][15:8] = reg_req.wdata;
				ADDR_OFF_Z_LO: s_nxt.offset[2][7:0] = reg_req.wdata;
				ADDR_CFG: s_nxt.cfg = reg_req.wdata;
				ADDR_THS_X_HI: begin
					s_nxt.dbcnt_clear_mode = reg_req.wdata[DBCNT_MODE_BIT];
					s_nxt.threshold[0][14:8] = reg_req.wdata[6:0];
				end
				ADDR_THS_X_LO: s_nxt.threshold[0][7:0] = reg_req.wdata;
				ADDR_THS_Y_HI: s_nxt.threshold[1][14:8] = reg_req.wdata[6:0];
				ADDR_THS_Y_LO: s_nxt.threshold[1][7:0] = reg_req.wdata;
				ADDR_THS_Z_HI: s_nxt.threshold[2][14:8] = reg_req.wdata[6:0];
				ADDR_THS_Z_LO: s_nxt.threshold[2][7:0] = reg_req.wdata;
				ADDR_COUNT: s_nxt.count = reg_req.wdata;
				default: ; // source register and unmapped addresses ignore writes
			endcase
		end

		// register reads; data appears one cycle after the strobe
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				ADDR_OFF_X_HI: s_nxt.rd_data = s_r.offset[0][15:8];
				ADDR_OFF_X_LO: s_nxt.rd_data = s_r.offset[0][7:0];
				ADDR_OFF_Y_HI: s_nxt.rd_data = s_r.offset[1][15:8];
				ADDR_OFF_Y_LO: s_nxt.rd_data = s_r.offset[1][7:0];
				ADDR_OFF_Z_HI: s_nxt.rd_data = s_r.offset[2][15:8];
				ADDR_OFF_Z_LO: s_nxt.rd_data = s_r.offset[2][7:0];
				ADDR_CFG: s_nxt.rd_data = s_r.cfg;
				ADDR_SRC: s_nxt.rd_data = src_view(s_r.flag, s_r.src_axis, axis_en);
				ADDR_THS_X_HI: s_nxt.rd_data = {s_r.dbcnt_clear_mode, s_r.threshold[0][14:8]};
				ADDR_THS_X_LO: s_nxt.rd_data = s_r.threshold[0][7:0];
				ADDR_THS_Y_HI: s_nxt.rd_data = {1'b0, s_r.threshold[1][14:8]};
				ADDR_THS_Y_LO: s_nxt.rd_data = s_r.threshold[1][7:0];
				ADDR_THS_Z_HI: s_nxt.rd_data = {1'b0, s_r.threshold[2][14:8]};
				ADDR_THS_Z_LO: s_nxt.rd_data = s_r.threshold[2][7:0];
				ADDR_COUNT: s_nxt.rd_data = s_r.count;
				default: s_nxt.rd_data = RST_BYTE;
			endcase
			// a source read releases a latched event; a set in the same cycle wins below
			if (reg_req.addr == ADDR_SRC && s_r.cfg[CFG_LATCH_BIT]) begin
				s_nxt.flag = 1'b0;
				s_nxt.src_axis = 6'h00;
			end
		end

		// evaluation only on a completed sample
		if (sample.valid) begin
			s_nxt.corr = val;
			s_nxt.corr_valid = 1'b1;
			s_nxt.dbcnt = cnt_nxt;
			if (s_r.cfg[CFG_LATCH_BIT]) begin
				if (detect) begin
					s_nxt.flag = 1'b1;
					s_nxt.src_axis = s_nxt.src_axis | src_bits;
				end
			end else begin
				s_nxt.flag = detect;
				s_nxt.src_axis = detect ? src_bits : 6'h00;
			end
		end

		// pin outputs follow the flag of this same update
		s_nxt.irq_one = irq_one_other
			| (s_nxt.flag & s_nxt.cfg[CFG_INT_EN_BIT] & s_nxt.cfg[CFG_ROUTE_BIT]);
		s_nxt.irq_two = irq_two_other
			| (s_nxt.flag & s_nxt.cfg[CFG_INT_EN_BIT] & ~s_nxt.cfg[CFG_ROUTE_BIT]);
		s_nxt.wake = s_nxt.flag & s_nxt.cfg[CFG_WAKE_BIT];
	end

	// single state register, synchronous reset to all zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_r <= MTD_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign rd_data = s_r.rd_data;
	assign corr_data = s_r.corr;
	assign corr_valid = s_r.corr_valid;
	assign irq_pin_one = s_r.irq_one;
	assign irq_pin_two = s_r.irq_two;
	assign wake_event = s_r.wake;

endmodule // mtd_threshold_detect

`default_nettype wire

// >>> dv/mtd_threshold_detect_properties.sv
// mtd_threshold_detect_properties: port level checks of the threshold block
`timescale 1ns/100ps
`default_nettype none
module mtd_threshold_detect_properties
	import mtd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire mtd_reg_req_s reg_req,
	input wire mtd_sample_s sample,
	input wire logic raw_output_sel,
	input wire logic irq_one_other,
	input wire logic irq_two_other,
	input wire logic [7:0] rd_data,
	input wire logic [2:0][15:0] corr_data,
	input wire logic corr_valid,
	input wire logic irq_pin_one,
	input wire logic irq_pin_two,
	input wire logic wake_event
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// a sample gets exactly one answer pulse, and nothing else makes one
	sequence smp_taken; sample.valid ##1 corr_valid; endsequence
	sequence smp_idle; !sample.valid ##1 !corr_valid; endsequence
	once_per_smp_a: assert property (sample.valid |-> smp_taken) else $error("sample lost");
	no_spare_a: assert property (!sample.valid |-> smp_idle) else $error("stray corr_valid");
	raw_pass_a: assert property (sample.valid && raw_output_sel |=> corr_data == $past(sample.axis))
		else $error("raw data altered");
	irq_or_one_a: assert property (irq_one_other |=> irq_pin_one) else $error("pin one lost");
	irq_or_two_a: assert property (irq_two_other |=> irq_pin_two) else $error("pin two lost");
	unmapped_rd_a: assert property (reg_req.rd && reg_req.addr == 8'h60 |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	// wake and pin two only rise after a sample, a register write, or for pin two through its other source
	wake_rise_a: assert property ($rose(wake_event) |-> $past(sample.valid || reg_req.wr))
		else $error("wake rose without cause");
	irq_rise_a: assert property ($rose(irq_pin_two) |-> $past(sample.valid || reg_req.wr || irq_two_other))
		else $error("pin two rose without cause");
endmodule // mtd_threshold_detect_properties

bind mtd_threshold_detect mtd_threshold_detect_properties mtd_threshold_detect_properties_i (
	.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .sample(sample),
	.raw_output_sel(raw_output_sel), .irq_one_other(irq_one_other), .irq_two_other(irq_two_other),
	.rd_data(rd_data), .corr_data(corr_data), .corr_valid(corr_valid), .irq_pin_one(irq_pin_one),
	.irq_pin_two(irq_pin_two), .wake_event(wake_event));
`default_nettype wire

// >>> dv/mtd_host.sv
// mtd_host: host side register master for the block's register port
`timescale 1ns/100ps
`default_nettype none
module mtd_host
	import mtd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] rd_data,
	output var mtd_reg_req_s req
);
	initial req = '0;
	// one strobe cycle per access; address and data inverted after, so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge sys_clk);
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge sys_clk);
		req = '{1'b0, 1'b0, ~a, 8'hff};
		d = rd_data;
	endtask
endmodule // mtd_host
`default_nettype wire

// >>> dv/mtd_threshold_detect_bench.sv
// mtd_threshold_detect_bench: self-checking bench of the magnetic threshold block
`timescale 1ns/100ps
`default_nettype none
module mtd_threshold_detect_bench;
	import mtd_pkg::*;
	typedef struct packed {logic raw; logic [15:0] off; logic [15:0] smp; logic [15:0] cor;} mtd_row_s;
	logic sys_clk, rst, raw_output_sel, irq_one_other, irq_two_other, corr_valid, irq_pin_one;
	logic irq_pin_two, wake_event;
	logic [7:0] rd_data, d;
	logic [2:0][15:0] corr_data;
	mtd_reg_req_s reg_req;
	mtd_sample_s sample;
	int failures = 0, samples_checked = 0, cycles = 0;
	// offset rows: plain, raw bypass, negative offset, saturation at full scale
	mtd_row_s rows [4] = '{'{1'b0, 16'h0010, 16'h0100, 16'h0110}, '{1'b1, 16'h0010, 16'h0100, 16'h0100},
		'{1'b0, 16'hfff0, 16'h0005, 16'hfff5}, '{1'b0, 16'h7fff, 16'h0001, 16'h7fff}};
	logic [7:0] ra [4] = '{ADDR_OFF_X_LO, ADDR_CFG, ADDR_SRC, 8'h60};
	logic [6:0] pat = 7'b0111011;
	logic [6:0] exp;
	mtd_threshold_detect mtd_threshold_detect_i (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
		.sample(sample), .raw_output_sel(raw_output_sel), .irq_one_other(irq_one_other),
		.irq_two_other(irq_two_other), .rd_data(rd_data), .corr_data(corr_data), .corr_valid(corr_valid),
		.irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two), .wake_event(wake_event));
	mtd_host mtd_host_i (.sys_clk(sys_clk), .rd_data(rd_data), .req(reg_req));
	// clock and hang guard; a real run needs well under a thousand cycles
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			test_done();
		end
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// one sample pulse; axes inverted after so a stale value is never mistaken for new data
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(negedge sys_clk);
		sample = '{1'b1, {z, y, x}};
		@(negedge sys_clk);
		sample = '{1'b0, {~z, ~y, ~x}};
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		raw_output_sel = 1'b0;
		irq_one_other = 1'b0;
		irq_two_other = 1'b0;
		sample = '0;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		foreach (ra[i]) begin
			mtd_host_i.rd(ra[i], d);
			chk("reset", d, 16'h0000);
		end
		foreach (rows[i]) begin
			raw_output_sel = rows[i].raw;
			mtd_host_i.wr(ADDR_OFF_X_HI, rows[i].off[15:8]);
			mtd_host_i.wr(ADDR_OFF_X_LO, rows[i].off[7:0]);
			smp(rows[i].smp, 16'h0000, 16'h0000);
			chk("corr", corr_data[0], rows[i].cor);
			chk("corr_valid", corr_valid, 1'b1);
		end
		raw_output_sel = 1'b0;
		// offset -50, threshold 100: raw -50 is below, corrected -100 meets it exactly
		mtd_host_i.wr(ADDR_OFF_X_HI, 8'hff);
		mtd_host_i.wr(ADDR_OFF_X_LO, 8'hce);
		mtd_host_i.wr(ADDR_THS_X_LO, 8'h64);
		mtd_host_i.wr(ADDR_THS_Y_LO, 8'h64);
		mtd_host_i.wr(ADDR_COUNT, 8'h03);
		mtd_host_i.wr(ADDR_CFG, 8'h4a);
		for (int m = 0; m < 2; m++) begin
			mtd_host_i.wr(ADDR_THS_X_HI, {m[0], 7'h00});
			smp(16'h0032, 16'h0000, 16'h0000);
			exp = m ? 7'h20 : 7'h30;
			for (int i = 0; i < 7; i++) begin
				smp(pat[i] ? 16'hffce : 16'h0032, 16'h0000, 16'h0000);
				chk("irq2", irq_pin_two, exp[i]);
			end
		end
		chk("irq1", irq_pin_one, 1'b0);
		// latched, routed to pin one, wake included, one-sample debounce
		mtd_host_i.wr(ADDR_COUNT, 8'h01);
		mtd_host_i.wr(ADDR_CFG, 8'hcf);
		smp(16'hffce, 16'h0000, 16'h0000);
		chk("wake", wake_event, 1'b1);
		smp(16'h0032, 16'h0000, 16'h0000);
		chk("irq1", irq_pin_one, 1'b1);
		mtd_host_i.rd(ADDR_SRC, d);
		chk("src", d, 16'h0083);
		smp(16'h0032, 16'h0000, 16'h0000);
		chk("irq1", irq_pin_one, 1'b0);
		// and mode on x and y, z disabled with a huge value, no debounce
		mtd_host_i.wr(ADDR_COUNT, 8'h00);
		mtd_host_i.wr(ADDR_CFG, 8'h1b);
		smp(16'h0032, 16'h0064, 16'h7000);
		chk("irq1", irq_pin_one, 1'b1);
		smp(16'h0032, 16'h0065, 16'h7000);
		chk("irq1", irq_pin_one, 1'b0);
		mtd_host_i.wr(ADDR_CFG, 8'h19);
		smp(16'h0032, 16'h0064, 16'h0000);
		chk("irq1", irq_pin_one, 1'b0);
		irq_one_other = 1'b1;
		irq_two_other = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("irq1", irq_pin_one, 1'b1);
		chk("irq2", irq_pin_two, 1'b1);
		// second reset in mid-run: the offset written earlier must return to zero
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		mtd_host_i.rd(ADDR_OFF_X_HI, d);
		chk("reset2", d, 16'h0000);
		test_done();
	end
endmodule // mtd_threshold_detect_bench
`default_nettype wire
